// ### design/crff_pkg.sv
// Shared constants for the CPU register file and flag register
package crff_pkg;
  localparam int DATA_W    = 16;
  localparam int WIDE_W    = 20;
  localparam int FLG_W     = 11;
  localparam int SEL_W     = 5;
  localparam int BANK_REGS = 7;
  localparam int PADDR_W   = 8;
  localparam int SEL_LSB   = 2;
  localparam int SEL_MSB   = 6;

  // Register selectors, shared by the core port and the APB map (byte address = 4 * code)
  localparam logic [4:0] SEL_DATA_WORD_ZERO     = 5'h00;
  localparam logic [4:0] SEL_DATA_WORD_ONE      = 5'h01;
  localparam logic [4:0] SEL_DATA_WORD_TWO      = 5'h02;
  localparam logic [4:0] SEL_DATA_WORD_THREE    = 5'h03;
  localparam logic [4:0] SEL_ADDR_PTR_ZERO      = 5'h04;
  localparam logic [4:0] SEL_ADDR_PTR_ONE       = 5'h05;
  localparam logic [4:0] SEL_FRAME_BASE         = 5'h06;
  localparam logic [4:0] SEL_VECTOR_TABLE_BASE  = 5'h07;
  localparam logic [4:0] SEL_NEXT_INSTR_POINTER = 5'h08;
  localparam logic [4:0] SEL_USER_STACK_PTR     = 5'h09;
  localparam logic [4:0] SEL_IRQ_STACK_PTR      = 5'h0a;
  localparam logic [4:0] SEL_STATIC_BASE        = 5'h0b;
  localparam logic [4:0] SEL_CPU_STATE_FLAGS    = 5'h0c;
  localparam logic [4:0] SEL_ACTIVE_STACK_PTR   = 5'h0d;
  localparam logic [4:0] SEL_DATA_ZERO_HIGH     = 5'h0e;
  localparam logic [4:0] SEL_DATA_ZERO_LOW      = 5'h0f;
  localparam logic [4:0] SEL_DATA_ONE_HIGH      = 5'h10;
  localparam logic [4:0] SEL_DATA_ONE_LOW       = 5'h11;
  localparam logic [4:0] SEL_DATA_LONG_LOW_PAIR = 5'h12;
  localparam logic [4:0] SEL_DATA_LONG_HIGH_PAIR = 5'h13;
  localparam logic [4:0] SEL_ADDR_LONG_PAIR     = 5'h14;

  // Flag register bit positions
  localparam int FLG_CARRY  = 0;
  localparam int FLG_DEBUG  = 1;
  localparam int FLG_ZERO   = 2;
  localparam int FLG_SIGN   = 3;
  localparam int FLG_BANK   = 4;
  localparam int FLG_OVF    = 5;
  localparam int FLG_IRQ_EN = 6;
  localparam int FLG_STACK  = 7;

  // Reset values
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [19:0] REG20_RST = 20'h00000;
  localparam logic [10:0] FLG_RST   = 11'h000;
endpackage

// ### design/crff_top.sv
// CPU register file: two register banks, pointers, program counter and flags
//
// Functional notes
// - thirteen registers, banked set duplicated twice
// - bank flag picks bank zero or one
// - four 16-bit data registers, general use
// - first two data registers split into bytes
// - data pairs form 32-bit, third/fourth upper
// - two 16-bit address registers, general use
// - address pair forms 32-bit, second upper
// - 16-bit frame base register
// - 20-bit interrupt vector table base
// - 20-bit next instruction pointer
// - two stack pointers, flag picks active
// - 16-bit static base register
// - 11-bit flag register with state bits
// - carry flag takes ALU carry/borrow/shift-out
// - zero flag set on zero result
// - sign flag set on negative result
// - overflow flag set on overflow
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module crff_top
  import crff_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               core_wr_en,
  input  wire logic [SEL_W-1:0]   core_wr_sel,
  input  wire logic [31:0]        core_wr_data,
  input  wire logic [SEL_W-1:0]   core_rd_sel,
  output logic      [31:0]        core_rd_data,
  input  wire logic               alu_c_en,
  input  wire logic               alu_carry,
  input  wire logic               alu_zs_en,
  input  wire logic               alu_byte,
  input  wire logic [DATA_W-1:0]  alu_result,
  input  wire logic               alu_o_en,
  input  wire logic               alu_overflow,
  output logic      [WIDE_W-1:0]  next_instr_pointer,
  output logic      [WIDE_W-1:0]  vector_table_base,
  output logic      [FLG_W-1:0]   cpu_state_flags
);

  logic [DATA_W-1:0] bank_reg [2][BANK_REGS];
  logic [WIDE_W-1:0] vector_table_base_reg;
  logic [WIDE_W-1:0] next_instr_pointer_reg;
  logic [DATA_W-1:0] user_stack_ptr_reg;
  logic [DATA_W-1:0] irq_stack_ptr_reg;
  logic [DATA_W-1:0] static_base_reg;
  logic [FLG_W-1:0]  flg_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       core_rd_data_reg;

  logic              apb_wr;
  logic [SEL_W-1:0]  apb_sel;
  logic              apb_bad;
  logic              bank_now;
  logic [FLG_W-1:0]  flg_next;
  logic [DATA_W-1:0] act_d0;
  logic [DATA_W-1:0] act_d2;
  logic [DATA_W-1:0] act_a0;
  logic [DATA_W-1:0] act_a1;

  // Apply one write source to one banked entry
  function automatic logic [DATA_W-1:0] bank_upd(
    input logic [DATA_W-1:0] cur,
    input int                idx,
    input logic              en,
    input logic [SEL_W-1:0]  sel,
    input logic [31:0]       d
  );
    bank_upd = cur;
    if (en)
    begin
      if (int'(sel) == idx && sel <= SEL_FRAME_BASE)
        bank_upd = d[15:0];
      else if ((sel == SEL_DATA_ZERO_HIGH && idx == 0) || (sel == SEL_DATA_ONE_HIGH && idx == 1))
        bank_upd = {d[7:0], cur[7:0]};
      else if ((sel == SEL_DATA_ZERO_LOW && idx == 0) || (sel == SEL_DATA_ONE_LOW && idx == 1))
        bank_upd = {cur[15:8], d[7:0]};
      else if ((sel == SEL_DATA_LONG_LOW_PAIR && idx == 0)
            || (sel == SEL_DATA_LONG_HIGH_PAIR && idx == 1)
            || (sel == SEL_ADDR_LONG_PAIR && idx == 4))
        bank_upd = d[15:0];
      else if ((sel == SEL_DATA_LONG_LOW_PAIR && idx == 2)
            || (sel == SEL_DATA_LONG_HIGH_PAIR && idx == 3)
            || (sel == SEL_ADDR_LONG_PAIR && idx == 5))
        bank_upd = d[31:16];
    end
  endfunction

  // Read view of any selector in the active bank
  function automatic logic [31:0] read_sel(input logic [SEL_W-1:0] s);
    logic b;
    b = flg_reg[FLG_BANK];
    read_sel = 32'h0000_0000;
    unique case (s)
      SEL_DATA_WORD_ZERO, SEL_DATA_WORD_ONE, SEL_DATA_WORD_TWO, SEL_DATA_WORD_THREE,
      SEL_ADDR_PTR_ZERO, SEL_ADDR_PTR_ONE, SEL_FRAME_BASE:
        read_sel = {16'h0000, bank_reg[b][s[2:0]]};
      SEL_VECTOR_TABLE_BASE:   read_sel = {12'h000, vector_table_base_reg};
      SEL_NEXT_INSTR_POINTER:  read_sel = {12'h000, next_instr_pointer_reg};
      SEL_USER_STACK_PTR:      read_sel = {16'h0000, user_stack_ptr_reg};
      SEL_IRQ_STACK_PTR:       read_sel = {16'h0000, irq_stack_ptr_reg};
      SEL_STATIC_BASE:         read_sel = {16'h0000, static_base_reg};
      SEL_CPU_STATE_FLAGS:     read_sel = {21'h000000, flg_reg};
      SEL_ACTIVE_STACK_PTR:
        read_sel = {16'h0000, flg_reg[FLG_STACK] ? user_stack_ptr_reg : irq_stack_ptr_reg};
      SEL_DATA_ZERO_HIGH:      read_sel = {24'h000000, bank_reg[b][0][15:8]};
      SEL_DATA_ZERO_LOW:       read_sel = {24'h000000, bank_reg[b][0][7:0]};
      SEL_DATA_ONE_HIGH:       read_sel = {24'h000000, bank_reg[b][1][15:8]};
      SEL_DATA_ONE_LOW:        read_sel = {24'h000000, bank_reg[b][1][7:0]};
      SEL_DATA_LONG_LOW_PAIR:  read_sel = {bank_reg[b][2], bank_reg[b][0]};
      SEL_DATA_LONG_HIGH_PAIR: read_sel = {bank_reg[b][3], bank_reg[b][1]};
      SEL_ADDR_LONG_PAIR:      read_sel = {bank_reg[b][5], bank_reg[b][4]};
      default:                 read_sel = 32'h0000_0000;
    endcase
  endfunction

  assign bank_now = flg_reg[FLG_BANK];
  assign act_d0   = bank_reg[bank_now][0];
  assign act_d2   = bank_reg[bank_now][2];
  assign act_a0   = bank_reg[bank_now][4];
  assign act_a1   = bank_reg[bank_now][5];

  // Address is held through the access phase, so it is decoded directly there
  assign apb_sel = paddr[SEL_MSB:SEL_LSB];
  assign apb_bad = paddr[PADDR_W-1] | (paddr[1:0] != 2'b00) | (apb_sel > SEL_ADDR_LONG_PAIR);
  assign apb_wr  = psel & penable & pwrite & pready_reg & ~pslverr_reg;

  // APB slave: one wait-free access phase; read data captured in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= apb_bad;
      prdata_reg  <= (pwrite || apb_bad) ? 32'h0000_0000 : read_sel(apb_sel);
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Core read port, one cycle of latency
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_rd_data_reg <= 32'h0000_0000;
    else
      core_rd_data_reg <= read_sel(core_rd_sel);
  end

  // Banked set; APB is applied after the core so it wins a same-register collision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < 2; b++)
        for (int i = 0; i < BANK_REGS; i++)
          bank_reg[b][i] <= REG16_RST;
    end
    else
    begin
      for (int i = 0; i < BANK_REGS; i++)
        bank_reg[bank_now][i] <= bank_upd(
          bank_upd(bank_reg[bank_now][i], i, core_wr_en, core_wr_sel, core_wr_data),
          i, apb_wr, apb_sel, pwdata);
    end
  end

  // Unbanked registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vector_table_base_reg  <= REG20_RST;
      next_instr_pointer_reg <= REG20_RST;
      user_stack_ptr_reg     <= REG16_RST;
      irq_stack_ptr_reg      <= REG16_RST;
      static_base_reg        <= REG16_RST;
    end
    else
    begin
      if (apb_wr && apb_sel == SEL_VECTOR_TABLE_BASE)
        vector_table_base_reg <= pwdata[19:0];
      else if (core_wr_en && core_wr_sel == SEL_VECTOR_TABLE_BASE)
        vector_table_base_reg <= core_wr_data[19:0];
      if (apb_wr && apb_sel == SEL_NEXT_INSTR_POINTER)
        next_instr_pointer_reg <= pwdata[19:0];
      else if (core_wr_en && core_wr_sel == SEL_NEXT_INSTR_POINTER)
        next_instr_pointer_reg <= core_wr_data[19:0];
      if (apb_wr && (apb_sel == SEL_USER_STACK_PTR
          || (apb_sel == SEL_ACTIVE_STACK_PTR && flg_reg[FLG_STACK])))
        user_stack_ptr_reg <= pwdata[15:0];
      else if (core_wr_en && (core_wr_sel == SEL_USER_STACK_PTR
               || (core_wr_sel == SEL_ACTIVE_STACK_PTR && flg_reg[FLG_STACK])))
        user_stack_ptr_reg <= core_wr_data[15:0];
      if (apb_wr && (apb_sel == SEL_IRQ_STACK_PTR
          || (apb_sel == SEL_ACTIVE_STACK_PTR && !flg_reg[FLG_STACK])))
        irq_stack_ptr_reg <= pwdata[15:0];
      else if (core_wr_en && (core_wr_sel == SEL_IRQ_STACK_PTR
               || (core_wr_sel == SEL_ACTIVE_STACK_PTR && !flg_reg[FLG_STACK])))
        irq_stack_ptr_reg <= core_wr_data[15:0];
      if (apb_wr && apb_sel == SEL_STATIC_BASE)
        static_base_reg <= pwdata[15:0];
      else if (core_wr_en && core_wr_sel == SEL_STATIC_BASE)
        static_base_reg <= core_wr_data[15:0];
    end
  end

  // Whole-register write first; ALU results then override their own bits
  always_comb
  begin
    flg_next = flg_reg;
    if (apb_wr && apb_sel == SEL_CPU_STATE_FLAGS)
      flg_next = pwdata[10:0];
    else if (core_wr_en && core_wr_sel == SEL_CPU_STATE_FLAGS)
      flg_next = core_wr_data[10:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flg_reg <= FLG_RST;
    else
    begin
      flg_reg <= flg_next;
      if (alu_c_en)
        flg_reg[FLG_CARRY] <= alu_carry;
      if (alu_zs_en)
      begin
        flg_reg[FLG_ZERO] <= alu_byte ? (alu_result[7:0] == 8'h00)
                                      : (alu_result == 16'h0000);
        flg_reg[FLG_SIGN] <= alu_byte ? alu_result[7] : alu_result[15];
      end
      if (alu_o_en)
        flg_reg[FLG_OVF] <= alu_overflow;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign core_rd_data       = core_rd_data_reg;
  assign next_instr_pointer = next_instr_pointer_reg;
  assign vector_table_base  = vector_table_base_reg;
  assign cpu_state_flags    = flg_reg;

  bank_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_wr_en && core_wr_sel == SEL_FRAME_BASE && !apb_wr && !flg_reg[FLG_BANK])
    |=> (bank_reg[0][6] == $past(core_wr_data[15:0])) && $stable(bank_reg[1][6]))
    else $error("frame base write went to the wrong bank");

  byte_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_wr_en && core_wr_sel == SEL_DATA_ZERO_HIGH && !apb_wr)
    |=> (act_d0[7:0] == $past(act_d0[7:0])) && (act_d0[15:8] == $past(core_wr_data[7:0])))
    else $error("high byte write disturbed the low byte");

  long_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_rd_sel == SEL_DATA_LONG_LOW_PAIR)
    |=> core_rd_data == {$past(act_d2), $past(act_d0)})
    else $error("data pair read in the wrong order");

  addr_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_wr_en && core_wr_sel == SEL_ADDR_LONG_PAIR && !apb_wr)
    |=> {act_a1, act_a0} == $past(core_wr_data))
    else $error("address pair write split wrongly");

  stack_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_rd_sel == SEL_ACTIVE_STACK_PTR)
    |=> core_rd_data[15:0] == ($past(flg_reg[FLG_STACK]) ? $past(user_stack_ptr_reg)
                                                         : $past(irq_stack_ptr_reg)))
    else $error("wrong stack pointer active");

  zero_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alu_zs_en && !alu_byte) |=> flg_reg[FLG_ZERO] == ($past(alu_result) == 16'h0000))
    else $error("zero flag does not match result");

  sign_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    alu_zs_en |=> flg_reg[FLG_SIGN] == ($past(alu_byte) ? $past(alu_result[7])
                                                        : $past(alu_result[15])))
    else $error("sign flag does not match result");

  carry_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    alu_c_en |=> flg_reg[FLG_CARRY] == $past(alu_carry))
    else $error("carry flag not captured");

  ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    alu_o_en |=> flg_reg[FLG_OVF] == $past(alu_overflow))
    else $error("overflow flag not captured");

  pc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_wr_en && core_wr_sel == SEL_NEXT_INSTR_POINTER && !apb_wr)
    |=> next_instr_pointer == $past(core_wr_data[19:0]))
    else $error("program counter write lost");

  bank_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && apb_sel == SEL_DATA_WORD_ZERO && flg_reg[FLG_BANK] && !core_wr_en)
    |=> (bank_reg[1][0] == $past(pwdata[15:0])) && $stable(bank_reg[0][0]))
    else $error("bank one write leaked into bank zero");

  low_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_wr_en && core_wr_sel == SEL_DATA_ONE_LOW && !apb_wr && !flg_reg[FLG_BANK])
    |=> bank_reg[0][1] == {$past(bank_reg[0][1][15:8]), $past(core_wr_data[7:0])})
    else $error("low byte write disturbed the high byte");

  table_base_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && apb_sel == SEL_VECTOR_TABLE_BASE)
    |=> vector_table_base == $past(pwdata[19:0]))
    else $error("vector table base write lost");

  // A refused address may alias selector zero, so data zero must hold in both banks
  bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pready && pslverr && !core_wr_en)
    |=> $stable(bank_reg[0][0]) && $stable(bank_reg[1][0]))
    else $error("refused APB write changed a data register");

  byte_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alu_zs_en && alu_byte) |=> flg_reg[FLG_ZERO] == ($past(alu_result[7:0]) == 8'h00))
    else $error("byte zero flag does not match result");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("APB access phase not answered in one cycle");

endmodule

// ### bench/crff_core_model.sv
// Behavioural model of the execution logic and arithmetic unit on the core side
`timescale 1ns/1ns
module crff_core_model
  import crff_pkg::*;
(
  input  wire logic              pclk,
  output logic                   core_wr_en,
  output logic      [SEL_W-1:0]  core_wr_sel,
  output logic      [31:0]       core_wr_data,
  output logic      [SEL_W-1:0]  core_rd_sel,
  input  wire logic [31:0]       core_rd_data,
  output logic                   alu_c_en,
  output logic                   alu_carry,
  output logic                   alu_zs_en,
  output logic                   alu_byte,
  output logic      [DATA_W-1:0] alu_result,
  output logic                   alu_o_en,
  output logic                   alu_overflow
);
  initial
  begin
    core_wr_en   = 1'b0;
    core_wr_sel  = 5'h00;
    core_wr_data = 32'h0000_0000;
    core_rd_sel  = 5'h00;
    alu_c_en     = 1'b0;
    alu_carry    = 1'b0;
    alu_zs_en    = 1'b0;
    alu_byte     = 1'b0;
    alu_result   = 16'h0000;
    alu_o_en     = 1'b0;
    alu_overflow = 1'b0;
  end

  task automatic core_write(input logic [SEL_W-1:0] s, input logic [31:0] d);
    @(posedge pclk);
    core_wr_en   <= 1'b1;
    core_wr_sel  <= s;
    core_wr_data <= d;
    @(posedge pclk);
    core_wr_en   <= 1'b0;
  endtask

  // Read data is registered, so it is taken two edges after the selector moves
  task automatic core_read(input logic [SEL_W-1:0] s, output logic [31:0] d);
    @(posedge pclk);
    core_rd_sel <= s;
    repeat (2) @(posedge pclk);
    d = core_rd_data;
  endtask

  // Word add; the model never writes the debug bit, so it stays clear
  task automatic alu_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    @(posedge pclk);
    alu_c_en     <= 1'b1;
    alu_carry    <= sum[16];
    alu_zs_en    <= 1'b1;
    alu_byte     <= 1'b0;
    alu_result   <= sum[15:0];
    alu_o_en     <= 1'b1;
    alu_overflow <= (a[15] == b[15]) && (sum[15] != a[15]);
    @(posedge pclk);
    alu_c_en     <= 1'b0;
    alu_zs_en    <= 1'b0;
    alu_o_en     <= 1'b0;
  endtask

  // Byte-wide result: zero and sign come from the low byte only
  task automatic alu_byte_res(input logic [15:0] res);
    @(posedge pclk);
    alu_zs_en  <= 1'b1;
    alu_byte   <= 1'b1;
    alu_result <= res;
    @(posedge pclk);
    alu_zs_en  <= 1'b0;
    alu_byte   <= 1'b0;
  endtask
endmodule

// ### bench/crff_top_test.sv
// Self-checking testbench for the CPU register file over APB and the core port
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
  begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module crff_top_test
  import crff_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, core_wr_data, core_rd_data, r;
  logic pready, pslverr, core_wr_en, alu_c_en, alu_carry, alu_zs_en, alu_byte;
  logic alu_o_en, alu_overflow;
  logic [4:0] core_wr_sel, core_rd_sel;
  logic [15:0] alu_result;
  logic [19:0] next_instr_pointer, vector_table_base;
  logic [10:0] cpu_state_flags;
  int failures = 0;
  int cmp_count = 0;

  crff_top i_crff_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_wr_en(core_wr_en), .core_wr_sel(core_wr_sel),
    .core_wr_data(core_wr_data), .core_rd_sel(core_rd_sel), .core_rd_data(core_rd_data),
    .alu_c_en(alu_c_en), .alu_carry(alu_carry), .alu_zs_en(alu_zs_en), .alu_byte(alu_byte),
    .alu_result(alu_result), .alu_o_en(alu_o_en), .alu_overflow(alu_overflow),
    .next_instr_pointer(next_instr_pointer), .vector_table_base(vector_table_base),
    .cpu_state_flags(cpu_state_flags));

  crff_core_model i_crff_core_model (.pclk(pclk), .core_wr_en(core_wr_en),
    .core_wr_sel(core_wr_sel), .core_wr_data(core_wr_data), .core_rd_sel(core_rd_sel),
    .core_rd_data(core_rd_data), .alu_c_en(alu_c_en), .alu_carry(alu_carry),
    .alu_zs_en(alu_zs_en), .alu_byte(alu_byte), .alu_result(alu_result),
    .alu_o_en(alu_o_en), .alu_overflow(alu_overflow));

  task end_sim;
    $display("comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: pready never came", $time);
      end_sim;
    end
  endtask

  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, {1'b0, s, 2'b00}, d, rd, e);
    `CHK(e, 1'b0, "write refused")
  endtask

  task automatic rd_chk(input logic [4:0] s, input logic [31:0] exp, input string m);
    logic [31:0] rd;
    logic e;
    apb(1'b0, {1'b0, s, 2'b00}, 32'h0, rd, e);
    `CHK(rd, exp, m)
    `CHK(e, 1'b0, m)
  endtask

  task automatic chk_reset;
    for (int i = 0; i < 13; i++)
      rd_chk(i[4:0], 32'h0, "reset value");
    `CHK(next_instr_pointer, 20'h00000, "pc reset")
    `CHK(cpu_state_flags, 11'h000, "flags reset")
  endtask

  // Flags go last so the banked writes all land in bank zero
  task automatic chk_widths;
    logic [31:0] m;
    for (int i = 0; i < 13; i++)
    begin
      m = (i == 7 || i == 8) ? 32'hfffff : (i == 12) ? 32'h7ff : 32'hffff;
      wr(i[4:0], 32'hffff_fffd);
      rd_chk(i[4:0], 32'hffff_fffd & m, "width");
    end
    `CHK(next_instr_pointer, 20'hffffd, "pc width")
    `CHK(vector_table_base, 20'hffffd, "table base width")
    `CHK(cpu_state_flags, 11'h7fd, "flags width")
  endtask

  task automatic chk_banks;
    rd_chk(SEL_DATA_WORD_ZERO, 32'h0, "bank one data");
    rd_chk(SEL_FRAME_BASE, 32'h0, "bank one frame");
    rd_chk(SEL_STATIC_BASE, 32'hfffd, "static unbanked");
    wr(SEL_DATA_WORD_ZERO, 32'h2222);
    wr(SEL_CPU_STATE_FLAGS, 32'h0);
    rd_chk(SEL_DATA_WORD_ZERO, 32'hfffd, "bank zero kept");
    wr(SEL_CPU_STATE_FLAGS, 32'h10);
    rd_chk(SEL_DATA_WORD_ZERO, 32'h2222, "bank one kept");
    wr(SEL_CPU_STATE_FLAGS, 32'h0);
  endtask

  task automatic chk_bytes;
    wr(SEL_DATA_WORD_ZERO, 32'habcd);
    i_crff_core_model.core_write(SEL_DATA_ZERO_HIGH, 32'h12);
    rd_chk(SEL_DATA_WORD_ZERO, 32'h12cd, "high byte");
    i_crff_core_model.core_write(SEL_DATA_ZERO_LOW, 32'h34);
    rd_chk(SEL_DATA_WORD_ZERO, 32'h1234, "low byte");
    wr(SEL_DATA_WORD_ONE, 32'h5566);
    i_crff_core_model.core_write(SEL_DATA_ONE_LOW, 32'h77);
    rd_chk(SEL_DATA_WORD_ONE, 32'h5577, "one low byte");
    i_crff_core_model.core_read(SEL_DATA_ONE_HIGH, r);
    `CHK(r[7:0], 8'h55, "one high byte read")
  endtask

  task automatic chk_pairs;
    i_crff_core_model.core_write(SEL_DATA_LONG_LOW_PAIR, 32'h89ab_cdef);
    rd_chk(SEL_DATA_WORD_TWO, 32'h89ab, "low pair upper");
    rd_chk(SEL_DATA_WORD_ZERO, 32'hcdef, "low pair lower");
    i_crff_core_model.core_write(SEL_DATA_LONG_HIGH_PAIR, 32'h1357_2468);
    rd_chk(SEL_DATA_WORD_THREE, 32'h1357, "high pair upper");
    rd_chk(SEL_DATA_WORD_ONE, 32'h2468, "high pair lower");
    i_crff_core_model.core_write(SEL_ADDR_LONG_PAIR, 32'h0f0e_0d0c);
    rd_chk(SEL_ADDR_PTR_ONE, 32'h0f0e, "addr pair upper");
    rd_chk(SEL_ADDR_PTR_ZERO, 32'h0d0c, "addr pair lower");
    i_crff_core_model.core_read(SEL_ADDR_LONG_PAIR, r);
    `CHK(r, 32'h0f0e_0d0c, "addr pair read")
  endtask

  // Core-side writes, a core pair read, then APB and core hitting one register at one edge
  task automatic chk_core;
    i_crff_core_model.core_write(SEL_FRAME_BASE, 32'h0000_4321);
    rd_chk(SEL_FRAME_BASE, 32'h4321, "core frame base");
    i_crff_core_model.core_write(SEL_NEXT_INSTR_POINTER, 32'h000a_bcde);
    @(negedge pclk);
    `CHK(next_instr_pointer, 20'habcde, "core pc write")
    i_crff_core_model.core_read(SEL_DATA_LONG_LOW_PAIR, r);
    `CHK(r, 32'h89ab_cdef, "low pair read")
    @(negedge pclk);
    fork
      wr(SEL_STATIC_BASE, 32'h5a5a);
      begin
        @(posedge pclk);
        i_crff_core_model.core_write(SEL_STATIC_BASE, 32'h1234);
      end
    join
    rd_chk(SEL_STATIC_BASE, 32'h5a5a, "apb wins collision");
  endtask

  task automatic chk_stack;
    wr(SEL_USER_STACK_PTR, 32'h1111);
    wr(SEL_IRQ_STACK_PTR, 32'h2222);
    i_crff_core_model.core_read(SEL_ACTIVE_STACK_PTR, r);
    `CHK(r[15:0], 16'h2222, "irq stack active")
    wr(SEL_CPU_STATE_FLAGS, 32'h80);
    i_crff_core_model.core_read(SEL_ACTIVE_STACK_PTR, r);
    `CHK(r[15:0], 16'h1111, "user stack active")
    wr(SEL_CPU_STATE_FLAGS, 32'h0);
  endtask

  // Bits 5:0 are overflow, bank, sign, zero, debug, carry
  task automatic chk_alu;
    i_crff_core_model.alu_add(16'hffff, 16'h0001);
    @(negedge pclk);
    `CHK(cpu_state_flags[5:0], 6'h05, "carry out to zero")
    i_crff_core_model.alu_add(16'h7fff, 16'h0001);
    @(negedge pclk);
    `CHK(cpu_state_flags[5:0], 6'h28, "signed overflow")
    i_crff_core_model.alu_add(16'h8000, 16'h8000);
    @(negedge pclk);
    `CHK(cpu_state_flags[5:0], 6'h25, "carry and overflow")
    i_crff_core_model.alu_byte_res(16'h0180);
    @(negedge pclk);
    `CHK(cpu_state_flags[5:0], 6'h29, "byte sign")
    i_crff_core_model.alu_byte_res(16'h0100);
    @(negedge pclk);
    `CHK(cpu_state_flags[5:0], 6'h25, "byte zero")
  endtask

  task automatic chk_bad_addr;
    logic [7:0] bad [3];
    logic e;
    bad = '{8'h54, 8'h02, 8'h80};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, bad[i], 32'hdead, r, e);
      `CHK(e, 1'b1, "bad write accepted")
      apb(1'b0, bad[i], 32'h0, r, e);
      `CHK({e, r}, {1'b1, 32'h0}, "bad read accepted")
    end
    rd_chk(SEL_DATA_WORD_ZERO, 32'hcdef, "bad write leaked");
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset;
    chk_widths;
    chk_banks;
    chk_bytes;
    chk_pairs;
    chk_core;
    chk_stack;
    chk_alu;
    chk_bad_addr;
    end_sim;
  end
endmodule
